// *** logic/scts_clock_control.sv ***
`timescale 1ns/1ps
`include "scts_cfg.svh"
module scts_clock_control
    import scts_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [`SCTS_SAMPLE_W-1:0] core_sample,
    input wire logic trigger_mark_input,
    input wire logic sysref_in,
    input wire logic mark_output_enable,
    input wire logic reference_as_mark_source,
    input wire logic single_channel_mode,
    input wire logic [3:0] demux_factor,
    input wire logic [3:0] frame_length,
    input wire logic half_period_invert_delay,
    input wire logic [`SCTS_DELAY_W-1:0] coarse_aperture_delay,
    input wire logic coarse_write,
    input wire logic [`SCTS_DELAY_W-1:0] fine_aperture_delay,
    input wire logic delay_ramp_on,
    input wire logic delay_ramp_speed,
    output logic [`SCTS_SAMPLE_W-1:0] sample_out,
    output logic output_strobe,
    output logic sample_falling_edge,
    output logic applied_invert,
    output logic [`SCTS_DELAY_W-1:0] applied_coarse,
    output logic [`SCTS_DELAY_W-1:0] applied_fine,
    output logic ramp_busy
);
    // Trigger sampled on the sampling clock, then delay matched
    logic mark_sampled;
    logic next_mark_sampled;
    logic mark_delayed;
    // Output sample register, one stage after core_sample
    logic [`SCTS_SAMPLE_W-1:0] next_sample_out;
    // Frame divider and strobe
    logic [`SCTS_DIV_W-1:0] div_cnt;
    logic [`SCTS_DIV_W-1:0] next_div_cnt;
    logic next_output_strobe;
    logic sysref_q;
    logic next_sysref_q;
    logic [`SCTS_DIV_W-1:0] frame_cycles;
    // Edge select
    logic next_sample_falling_edge;
    // Delay controls
    logic next_applied_invert;
    logic [`SCTS_DELAY_W-1:0] next_applied_fine;
    logic [`SCTS_DELAY_W-1:0] next_applied_coarse;
    logic [`SCTS_DELAY_W-1:0] target;
    logic [`SCTS_DELAY_W-1:0] next_target;
    logic [`SCTS_RAMP_CNT_W-1:0] ramp_cnt;
    logic [`SCTS_RAMP_CNT_W-1:0] next_ramp_cnt;
    scts_ramp_state_type state;
    scts_ramp_state_type next_state;
    logic next_ramp_busy;

    // One step toward target, clamped so it never overshoots
    function automatic logic [`SCTS_DELAY_W-1:0] step_toward(
        input logic [`SCTS_DELAY_W-1:0] cur,
        input logic [`SCTS_DELAY_W-1:0] tgt,
        input logic [`SCTS_DELAY_W-1:0] step
    );
        logic [`SCTS_DELAY_W-1:0] diff;
        diff = '0;
        if (tgt > cur) begin
            diff = tgt - cur;
            step_toward = (diff < step) ? tgt : cur + step;
        end else begin
            diff = cur - tgt;
            step_toward = (diff < step) ? tgt : cur - step;
        end
    endfunction

    // Mark source select and sampling on the device clock
    always_comb begin
        next_mark_sampled = reference_as_mark_source ? sysref_in
                                                     : trigger_mark_input;
        next_sysref_q = sysref_in;
    end

    // Delay line for the mark bit
    scts_mark_pipe u_mark_pipe (
        .clk(clk),
        .nrst(nrst),
        .mark_in(mark_sampled),
        .mark_out(mark_delayed)
    );

    // Output word; core_sample arrives already through the core pipeline
    always_comb begin
        if (mark_output_enable) begin
            next_sample_out = {core_sample[`SCTS_SAMPLE_W-1:1], mark_delayed};
        end else begin
            next_sample_out = core_sample;
        end
    end

    // Frame length in device clocks: (demux + 1) x frame length
    always_comb begin
        frame_cycles = `SCTS_DIV_W'({4'h0, demux_factor} + 8'h01)
                       * `SCTS_DIV_W'(frame_length);
        next_output_strobe = 1'b0;
        if (sysref_in && !sysref_q) begin
            next_div_cnt = '0;
            next_output_strobe = 1'b1;
        end else if (div_cnt + 8'h01 >= frame_cycles) begin
            next_div_cnt = '0;
            next_output_strobe = 1'b1;
        end else begin
            next_div_cnt = div_cnt + 8'h01;
        end
    end

    // Edge usage: single-channel samples also on the falling edge
    always_comb begin
        next_sample_falling_edge = single_channel_mode;
    end

    // Ramp engine for the coarse delay
    always_comb begin
        next_state = state;
        next_target = target;
        next_ramp_cnt = ramp_cnt;
        next_applied_coarse = applied_coarse;
        next_applied_invert = half_period_invert_delay;
        next_applied_fine = fine_aperture_delay;
        if (coarse_write) begin
            next_target = coarse_aperture_delay;
        end
        case (state)
            SCTS_IDLE: begin
                if (coarse_write && !delay_ramp_on) begin
                    next_applied_coarse = coarse_aperture_delay;
                end else if (coarse_write &&
                             coarse_aperture_delay != applied_coarse) begin
                    next_state = SCTS_RAMP;
                    next_ramp_cnt = '0;
                end
            end
            SCTS_RAMP: begin
                if (!delay_ramp_on) begin
                    next_applied_coarse = next_target;
                    next_state = SCTS_IDLE;
                end else if (coarse_write) begin
                    next_ramp_cnt = '0;
                end else if (ramp_cnt ==
                        `SCTS_RAMP_CNT_W'(`SCTS_RAMP_PERIOD - 1)) begin
                    next_ramp_cnt = '0;
                    next_applied_coarse = step_toward(applied_coarse, target,
                        delay_ramp_speed ? `SCTS_STEP_FAST : `SCTS_STEP_SLOW);
                    if (next_applied_coarse == target) begin
                        next_state = SCTS_IDLE;
                    end
                end else begin
                    next_ramp_cnt = ramp_cnt + 8'h01;
                end
            end
            default: begin
                next_state = SCTS_IDLE;
            end
        endcase
        next_ramp_busy = (next_state == SCTS_RAMP);
    end

    // All state on the single device clock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mark_sampled <= 1'b0;
            sysref_q <= 1'b0;
            sample_out <= '0;
            div_cnt <= '0;
            output_strobe <= 1'b0;
            sample_falling_edge <= 1'b0;
            applied_invert <= 1'b0;
            applied_fine <= `SCTS_DELAY_RST;
            applied_coarse <= `SCTS_DELAY_RST;
            target <= `SCTS_DELAY_RST;
            ramp_cnt <= '0;
            state <= SCTS_IDLE;
            ramp_busy <= 1'b0;
        end else begin
            mark_sampled <= next_mark_sampled;
            sysref_q <= next_sysref_q;
            sample_out <= next_sample_out;
            div_cnt <= next_div_cnt;
            output_strobe <= next_output_strobe;
            sample_falling_edge <= next_sample_falling_edge;
            applied_invert <= next_applied_invert;
            applied_fine <= next_applied_fine;
            applied_coarse <= next_applied_coarse;
            target <= next_target;
            ramp_cnt <= next_ramp_cnt;
            state <= next_state;
            ramp_busy <= next_ramp_busy;
        end
    end

    // Raw converter word passes through while marking is off
    raw_passthru_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst && !mark_output_enable |=> sample_out == $past(core_sample))
        else $error("raw sample not passed");

    // Output LSB carries the delayed mark while marking is on
    mark_lsb_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst && mark_output_enable |=> sample_out[0] == $past(mark_delayed))
        else $error("mark bit wrong");

    // Seven settled cycles: the LSB shows the trigger six edges back
    mark_latency_a: assert property (@(posedge clk)
        disable iff (!nrst)
        (nrst && !reference_as_mark_source && mark_output_enable)[*7] |->
        sample_out[0] == $past(trigger_mark_input, 6))
        else $error("mark latency wrong");

    // Reference input feeds the mark sampler when selected
    ref_source_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst && reference_as_mark_source |=> mark_sampled == $past(sysref_in))
        else $error("reference not used as mark");

    // Reference rise restarts the divider and fires the strobe
    ref_reset_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst && sysref_in && !sysref_q |=> output_strobe && div_cnt == 8'h00)
        else $error("reference did not reset divider");

    // A strobe only ever stands on a fresh frame count
    strobe_restart_a: assert property (@(posedge clk)
        disable iff (!nrst)
        output_strobe |-> div_cnt == 8'h00)
        else $error("strobe off frame start");

    // Falling-edge sampling follows the channel mode
    edge_mode_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst |=> sample_falling_edge == $past(single_channel_mode))
        else $error("edge select wrong");

    // Half-period invert applies on the next clock
    invert_apply_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst |=> applied_invert == $past(half_period_invert_delay))
        else $error("invert not applied");

    // Fine delay applies on the next clock, apart from coarse
    fine_apply_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst |=> applied_fine == $past(fine_aperture_delay))
        else $error("fine delay not applied");

    // Coarse delay holds between ramp steps
    ramp_hold_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst && ramp_busy && delay_ramp_on && ramp_cnt != 8'hff |=>
        $stable(applied_coarse))
        else $error("coarse moved between steps");

    // Slow ramp moves one step at the end of each interval
    ramp_step_a: assert property (@(posedge clk)
        disable iff (!nrst)
        ramp_busy && delay_ramp_on && !coarse_write && ramp_cnt == 8'hff
        && !delay_ramp_speed && applied_coarse < target |=>
        applied_coarse == $past(applied_coarse) + 8'h01)
        else $error("slow step wrong");

    // Fast ramp moves four steps when the target is far enough
    fast_step_a: assert property (@(posedge clk)
        disable iff (!nrst)
        ramp_busy && delay_ramp_on && !coarse_write && ramp_cnt == 8'hff
        && delay_ramp_speed && applied_coarse < target
        && target - applied_coarse >= 8'h04 |=>
        applied_coarse == $past(applied_coarse) + 8'h04)
        else $error("fast step wrong");

    // A ramp that ends untouched ends on its target
    ramp_land_a: assert property (@(posedge clk)
        disable iff (!nrst)
        (ramp_busy && !coarse_write) ##1 !ramp_busy |->
        applied_coarse == target)
        else $error("ramp ended off target");

    // With ramping off a written coarse value lands at once
    direct_write_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst && !ramp_busy && !delay_ramp_on && coarse_write |=>
        applied_coarse == $past(coarse_aperture_delay))
        else $error("direct coarse write lost");

    // A differing write with ramping on starts a ramp, no jump
    ramp_start_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst && !ramp_busy && delay_ramp_on && coarse_write
        && coarse_aperture_delay != applied_coarse |=>
        ramp_busy && applied_coarse == $past(applied_coarse))
        else $error("ramp did not start");

    // Without a write an idle ramp engine stays idle
    ramp_idle_a: assert property (@(posedge clk)
        disable iff (!nrst)
        nrst && !ramp_busy && !coarse_write |=> !ramp_busy)
        else $error("ramp started without a write");
endmodule // scts_clock_control

// *** logic/scts_cfg.svh ***
`ifndef SCTS_CFG_SVH
`define SCTS_CFG_SVH

// Sample and delay widths
`define SCTS_SAMPLE_W 12
`define SCTS_DELAY_W 8
// Converter core pipeline latency in clock cycles (mark path matches it)
`define SCTS_PIPE_LAT 4
// Ramp step interval in clock cycles
`define SCTS_RAMP_PERIOD 256
`define SCTS_RAMP_CNT_W 8
// Coarse steps per interval, slow and fast
`define SCTS_STEP_SLOW 8'h01
`define SCTS_STEP_FAST 8'h04
// Reset value and divider width
`define SCTS_DELAY_RST 8'h00
`define SCTS_DIV_W 8

`endif

// *** logic/scts_pkg.sv ***
package scts_pkg;
    // Ramp engine states
    typedef enum logic [1:0] {
        SCTS_IDLE = 2'b01,
        SCTS_RAMP = 2'b10
    } scts_ramp_state_type;
endpackage

// *** logic/scts_mark_pipe.sv ***
`timescale 1ns/1ps
`include "scts_cfg.svh"

// Delay line for the mark bit, length equal to the core pipeline
module scts_mark_pipe (
    input wire logic clk,
    input wire logic nrst,
    input wire logic mark_in,
    output logic mark_out
);
    // Shift stages
    logic [`SCTS_PIPE_LAT-1:0] stage;
    logic [`SCTS_PIPE_LAT-1:0] next_stage;

    // Shift in the new mark each cycle
    always_comb begin
        next_stage = {stage[`SCTS_PIPE_LAT-2:0], mark_in};
    end

    // Register the stages
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stage <= '0;
        end else begin
            stage <= next_stage;
        end
    end

    assign mark_out = stage[`SCTS_PIPE_LAT-1];
endmodule // scts_mark_pipe

// *** dv/scts_src_model.sv ***
`timescale 1ns/1ps

// Far-side sources: trigger and system reference, both clock-unrelated
module scts_src_model (
    input wire logic trig_req,
    input wire logic ref_req,
    output logic trigger_mark_input,
    output logic sysref_in
);
    // Trigger edges land mid-cycle, off the sampling edge
    assign #7 trigger_mark_input = trig_req;
    // Reference follows the request, delayed the same 7 ns
    assign #7 sysref_in = ref_req;
endmodule // scts_src_model

// *** dv/scts_clock_control_tb_top.sv ***
`timescale 1ns/1ps
`include "scts_cfg.svh"

module scts_clock_control_tb_top;
    logic clk = 1'b0; // One device clock for everything
    logic nrst = 1'b0;
    logic [11:0] core = 12'hab5; // Odd LSB exposes mark leaks
    logic trig_req = 1'b0, ref_req = 1'b0, trig, sref;
    logic mark_en = 1'b0, ref_src = 1'b0, single = 1'b0;
    logic inv = 1'b0, cwr = 1'b0, ramp_on = 1'b0, fast = 1'b0;
    logic [7:0] coarse = 8'h00, fine = 8'h00, ac, af;
    logic [11:0] sout;
    logic strobe, fall, ainv, busy;
    int errors = 0, comparisons = 0, n;

    scts_src_model u_scts_src_model (.trig_req(trig_req),
        .ref_req(ref_req), .trigger_mark_input(trig), .sysref_in(sref));
    scts_clock_control u_scts_clock_control (.clk(clk), .nrst(nrst),
        .core_sample(core), .trigger_mark_input(trig), .sysref_in(sref),
        .mark_output_enable(mark_en), .reference_as_mark_source(ref_src),
        .single_channel_mode(single), .demux_factor(4'h0),
        .frame_length(4'hf), .half_period_invert_delay(inv),
        .coarse_aperture_delay(coarse), .coarse_write(cwr),
        .fine_aperture_delay(fine), .delay_ramp_on(ramp_on),
        .delay_ramp_speed(fast), .sample_out(sout), .output_strobe(strobe),
        .sample_falling_edge(fall), .applied_invert(ainv),
        .applied_coarse(ac), .applied_fine(af), .ramp_busy(busy));

    // 50 MHz clock
    always #10 clk = ~clk;

    // Compare and count
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Print counts and verdict
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One-cycle pulse on a source, then watch the mark bit
    task automatic mark_pulse(input logic use_ref);
        @(posedge clk);
        if (use_ref) begin
            ref_req <= 1'b1;
        end else begin
            trig_req <= 1'b1;
        end
        for (int i = 1; i <= 9; i++) begin
            @(posedge clk);
            if (i == 1) begin
                ref_req <= 1'b0;
                trig_req <= 1'b0;
            end
            #1;
            check(sout[0], 12'(i == 6));
            check(sout[11:1], core[11:1]);
        end
    endtask

    // Coarse target write with a one-cycle strobe
    task automatic write_coarse(input logic [7:0] v);
        @(posedge clk);
        coarse <= v;
        cwr <= 1'b1;
        @(posedge clk);
        cwr <= 1'b0;
    endtask

    // Cycles until the applied coarse delay moves, bounded
    task automatic next_step;
        logic [7:0] prev;
        prev = ac;
        n = 0;
        while (ac === prev && n < 600) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 600) begin
            errors++;
            report_and_stop;
        end
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1;
        check({sout[10:0], strobe}, 12'h000);
        check({ac, busy, ainv, fall}, 12'h000);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(sout, core);
        mark_en <= 1'b1;
        mark_pulse(1'b0);
        ref_src <= 1'b1;
        mark_pulse(1'b1);
        // Reference rise restarts the frame count
        @(posedge clk);
        ref_req <= 1'b1;
        @(posedge clk);
        ref_req <= 1'b0;
        // Strobe stands for one cycle only; look once it has settled
        #1;
        n = 0;
        while (!(strobe === 1'b1) && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(12'(n < 4), 12'h001);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!(strobe === 1'b1) && n < 40);
        check(12'(n), 12'd15);
        single <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        #1;
        check(fall, 1'b1);
        // Invert and fine apply together, coarse untouched
        @(posedge clk);
        inv <= 1'b1;
        fine <= 8'hff;
        @(posedge clk);
        @(posedge clk);
        #1;
        check({ainv, af, 3'b000}, {1'b1, 8'hff, 3'b000});
        check(ac, 8'h00);
        write_coarse(8'h40);
        #1;
        check(ac, 8'h40);
        write_coarse(8'h00);
        #1;
        check(ac, 8'h00);
        // Slow ramp to two
        ramp_on <= 1'b1;
        write_coarse(8'h02);
        next_step;
        check({ac, busy}, {8'h01, 1'b1});
        check(sout, 12'hab4);
        next_step;
        check(n, 256);
        check({ac, busy}, {8'h02, 1'b0});
        // Fast ramp with clamped last step
        fast <= 1'b1;
        write_coarse(8'h0b);
        next_step;
        check(ac, 8'h06);
        next_step;
        check(n, 256);
        check(ac, 8'h0a);
        next_step;
        check(ac, 8'h0b);
        // Downward ramp retargeted mid-way
        write_coarse(8'h00);
        next_step;
        check(ac, 8'h07);
        write_coarse(8'h09);
        next_step;
        check({ac, busy}, {8'h09, 1'b0});
        report_and_stop;
    end
endmodule // scts_clock_control_tb_top
